// file: pio_pkg.sv
// Package with register map, field layouts and carrier types for the shared parallel I/O port.
package pio_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] DIR_OFFSET = 12'h000;
  localparam logic [11:0] LATCH_OFFSET = 12'h004;
  localparam logic [11:0] PINVAL_OFFSET = 12'h008;
  localparam logic [11:0] PERIPH_EN_OFFSET = 12'h00C;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int PORT_LSB = 0;
  localparam int PORT_WIDTH = 16;
  localparam logic [15:0] PINS_USED = 16'h0FFF;
  localparam logic [15:0] DIR_RESET = 16'hFFFF;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic [15:0] PERIPH_EN_RESET = 16'h0000;
  localparam int SYNC_STAGES = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } pad_drive_s;

  typedef struct packed {
    logic [15:0] out;
    logic [15:0] drive;
  } periph_drive_s;

endpackage

// file: pin_sync.sv
// Two-stage synchroniser for the pad input levels.
module pin_sync
  import pio_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_s;

  sync_state_s st_r;
  sync_state_s st_nxt;

  // The first stage feeds only the second one.
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = din;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.sync;

endmodule

// file: pad_mux.sv
// Per-pin output data and enable multiplexers between peripheral and port.
module pad_mux
  import pio_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH,
  parameter logic [WIDTH-1:0] USED = PINS_USED
) (
  // Port side
  input wire logic [WIDTH-1:0] dir,
  input wire logic [WIDTH-1:0] latch,
  // Peripheral side
  input wire logic [WIDTH-1:0] periph_en,
  input wire logic [WIDTH-1:0] periph_out,
  input wire logic [WIDTH-1:0] periph_drive,
  // Pad side
  output logic [WIDTH-1:0] pad_out,
  output logic [WIDTH-1:0] pad_oe
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      logic owned;
      // Input-only peripherals never raise drive, so their pins stay plain port pins.
      assign owned = periph_en[i] & periph_drive[i];
      assign pad_out[i] = USED[i] & (owned ? periph_out[i] : latch[i]);
      assign pad_oe[i] = USED[i] & (owned ? 1'b1 : ~dir[i]);
    end
  endgenerate

endmodule

// file: shared_parallel_io_port.sv
// Shared parallel I/O port with AXI4-Lite register access.
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
module shared_parallel_io_port
  import pio_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH,
  parameter logic [PORT_WIDTH-1:0] USED = PINS_USED
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Peripherals sharing the pins
  input wire periph_drive_s periph,
  // Pads
  input wire logic [PORT_WIDTH-1:0] pad_in,
  output pad_drive_s pad
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (WIDTH != PORT_WIDTH) begin : g_width_check
    $error("WIDTH must equal PORT_WIDTH");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [1:0] {
    W_IDLE,
    W_RESP
  } wr_state_e;

  typedef struct packed {
    wr_state_e wst;
    logic aw_got;
    logic w_got;
    logic [11:0] waddr;
    logic [31:0] wdat;
    logic [3:0] wstb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] dir;
    logic [15:0] latch;
    logic [15:0] periph_en;
    pad_drive_s pad;
  } port_state_s;

  port_state_s st_r;
  port_state_s st_nxt;
  logic [15:0] pins_sync;
  logic [15:0] mux_out;
  logic [15:0] mux_oe;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r & USED;
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    return (a == DIR_OFFSET) || (a == LATCH_OFFSET) || (a == PINVAL_OFFSET) || (a == PERIPH_EN_OFFSET);
  endfunction

  // ****************************************************************
  // Pin input path and pad multiplexers
  // ****************************************************************
  pin_sync #(
    .WIDTH(PORT_WIDTH)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(pad_in),
    .dout(pins_sync)
  );

  // Every implemented pin (USED) of this port is shared; supply, clear and oscillator pins never reach it.
  pad_mux #(
    .WIDTH(PORT_WIDTH),
    .USED(USED)
  ) u_mux (
    .dir(st_r.dir),
    .latch(st_r.latch),
    .periph_en(st_r.periph_en),
    .periph_out(periph.out),
    .periph_drive(periph.drive),
    .pad_out(mux_out),
    .pad_oe(mux_oe)
  );

  // ****************************************************************
  // Register file and bus slave
  // ****************************************************************
  always_comb begin
    logic [11:0] ra;
    ra = {araddr[11:2], 2'b00};
    st_nxt = st_r;
    st_nxt.pad.out = mux_out;
    st_nxt.pad.oe = mux_oe;

    // Write channel: address and data are taken in either order.
    st_nxt.awready = 1'b0;
    st_nxt.wready = 1'b0;
    unique case (st_r.wst)
      W_IDLE: begin
        if (awvalid && !st_r.aw_got && !st_r.awready) begin
          st_nxt.awready = 1'b1;
          st_nxt.aw_got = 1'b1;
          st_nxt.waddr = {awaddr[11:2], 2'b00};
        end
        if (wvalid && !st_r.w_got && !st_r.wready) begin
          st_nxt.wready = 1'b1;
          st_nxt.w_got = 1'b1;
          st_nxt.wdat = wdata;
          st_nxt.wstb = wstrb;
        end
        if (st_r.aw_got && st_r.w_got) begin
          st_nxt.bvalid = 1'b1;
          st_nxt.bresp = is_mapped(st_r.waddr) ? RESP_OKAY : RESP_SLVERR;
          st_nxt.wst = W_RESP;
          if (st_r.waddr == DIR_OFFSET) begin
            st_nxt.dir = merge16(st_r.dir, st_r.wdat, st_r.wstb);
          end
          if (st_r.waddr == LATCH_OFFSET || st_r.waddr == PINVAL_OFFSET) begin
            st_nxt.latch = merge16(st_r.latch, st_r.wdat, st_r.wstb);
          end
          if (st_r.waddr == PERIPH_EN_OFFSET) begin
            st_nxt.periph_en = merge16(st_r.periph_en, st_r.wdat, st_r.wstb);
          end
        end
      end
      W_RESP: begin
        if (bready) begin
          st_nxt.bvalid = 1'b0;
          st_nxt.aw_got = 1'b0;
          st_nxt.w_got = 1'b0;
          st_nxt.wst = W_IDLE;
        end
      end
      default: begin
        st_nxt.wst = W_IDLE;
      end
    endcase

    // Read channel: one read in flight; data is registered one cycle after the address.
    st_nxt.arready = 1'b0;
    if (st_r.rvalid) begin
      if (rready) begin
        st_nxt.rvalid = 1'b0;
      end
    end else if (arvalid && !st_r.arready) begin
      st_nxt.arready = 1'b1;
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = is_mapped(ra) ? RESP_OKAY : RESP_SLVERR;
      st_nxt.rdata = 32'h0000_0000;
      if (ra == DIR_OFFSET) begin
        st_nxt.rdata[15:0] = st_r.dir & USED;
      end else if (ra == LATCH_OFFSET) begin
        st_nxt.rdata[15:0] = st_r.latch & USED;
      end else if (ra == PINVAL_OFFSET) begin
        st_nxt.rdata[15:0] = pins_sync & USED;
      end else if (ra == PERIPH_EN_OFFSET) begin
        st_nxt.rdata[15:0] = st_r.periph_en;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.wst <= W_IDLE;
      st_r.dir <= DIR_RESET & USED;
      st_r.latch <= LATCH_RESET;
      st_r.periph_en <= PERIPH_EN_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign awready = st_r.awready;
  assign wready = st_r.wready;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign arready = st_r.arready;
  assign rvalid = st_r.rvalid;
  assign rdata = st_r.rdata;
  assign rresp = st_r.rresp;
  assign pad = st_r.pad;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // The pad drive is registered, so every pad check looks one edge back at what fed the multiplexers.
  // Whole-port checks compare masks so that a single wrong pin anywhere shows up.
  AST_OWNED_DRIVES: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.periph_en[0] && periph.drive[0] && USED[0]) |=> (pad.oe[0] && pad.out[0] == $past(periph.out[0])))
    else $error("Driving peripheral did not own pad 0.");

  AST_NOT_DRIVING_PORT: assert property (@(posedge aclk) disable iff (!aresetn)
    (!periph.drive[0] && USED[0]) |=> (pad.oe[0] == !$past(st_r.dir[0]) && pad.out[0] == $past(st_r.latch[0])))
    else $error("Port did not drive pad 0 from its latch.");

  AST_DIR_INPUT: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.dir[1] && !(st_r.periph_en[1] && periph.drive[1])) |=> !pad.oe[1])
    else $error("Input pin was driven.");

  AST_RESET_INPUTS: assert property (@(posedge aclk)
    !aresetn |=> (st_r.dir == (DIR_RESET & USED)))
    else $error("Direction bits not set after reset.");

  AST_LATCH_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.wst == W_IDLE && st_r.aw_got && st_r.w_got && st_r.waddr == PINVAL_OFFSET && st_r.wstb == 4'hF)
    |=> st_r.latch == ($past(st_r.wdat[15:0]) & USED))
    else $error("Pin-value write did not reach the latch.");

  AST_PIN_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && !st_r.rvalid && !st_r.arready && {araddr[11:2], 2'b00} == PINVAL_OFFSET)
    |=> rdata[15:0] == ($past(pad_in, 3) & USED))
    else $error("Pin-value read lost its level or sync depth.");

  AST_UNUSED_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid |-> ((rdata[15:0] & ~USED) == 16'h0000))
    else $error("Unimplemented bit read nonzero.");

  AST_UNUSED_NO_DRIVE: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 ((pad.oe & ~USED) == 16'h0000))
    else $error("Unimplemented pin driven.");

  AST_LATCH_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && !st_r.rvalid && !st_r.arready && {araddr[11:2], 2'b00} == LATCH_OFFSET)
    |=> rdata[15:0] == $past(st_r.latch))
    else $error("Latch read mismatch.");

  AST_OWNED_OE_ALL: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 ((~pad.oe & $past(st_r.periph_en) & $past(periph.drive) & USED) == 16'h0000))
    else $error("Owned pad lost its output enable.");

  AST_OWNED_DATA_ALL: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (((pad.out ^ $past(periph.out)) & $past(st_r.periph_en) & $past(periph.drive) & USED) == 16'h0000))
    else $error("Owned pad did not carry peripheral data.");

  AST_PORT_OE_ALL: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (((pad.oe ^ ~$past(st_r.dir)) & ~($past(st_r.periph_en) & $past(periph.drive)) & USED) == 16'h0000))
    else $error("Port pad enable does not follow direction.");

  AST_PORT_DATA_ALL: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (((pad.out ^ $past(st_r.latch)) & ~($past(st_r.periph_en) & $past(periph.drive)) & USED) == 16'h0000))
    else $error("Port pad data does not follow the latch.");

  AST_INPUT_ONLY_PORT: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (((pad.oe ^ ~$past(st_r.dir)) & ~$past(periph.drive) & USED) == 16'h0000))
    else $error("Pin of a non-driving peripheral is not a plain port pin.");

  AST_DIR_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && !st_r.rvalid && !st_r.arready && {araddr[11:2], 2'b00} == DIR_OFFSET)
    |=> rdata[15:0] == $past(st_r.dir))
    else $error("Direction read mismatch.");

  AST_PERIPH_EN_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && !st_r.rvalid && !st_r.arready && {araddr[11:2], 2'b00} == PERIPH_EN_OFFSET)
    |=> rdata[15:0] == $past(st_r.periph_en))
    else $error("Peripheral enable read mismatch.");

  AST_DIR_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.wst == W_IDLE && st_r.aw_got && st_r.w_got && st_r.waddr == DIR_OFFSET && st_r.wstb == 4'hF)
    |=> st_r.dir == ($past(st_r.wdat[15:0]) & USED))
    else $error("Direction write did not land.");

  AST_LATCH_REG_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.wst == W_IDLE && st_r.aw_got && st_r.w_got && st_r.waddr == LATCH_OFFSET && st_r.wstb == 4'hF)
    |=> st_r.latch == ($past(st_r.wdat[15:0]) & USED))
    else $error("Latch write did not land.");

  AST_PIN_WRITE_ONLY_LATCH: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.wst == W_IDLE && st_r.aw_got && st_r.w_got && st_r.waddr == PINVAL_OFFSET)
    |=> ($stable(st_r.dir) && $stable(st_r.periph_en)))
    else $error("Pin-value write touched more than the latch.");

  AST_RESET_STATE: assert property (@(posedge aclk)
    !aresetn |=> (pad.oe == 16'h0000 && st_r.latch == LATCH_RESET && st_r.periph_en == PERIPH_EN_RESET))
    else $error("Pads or registers not cleared by reset.");

  AST_UNUSED_STATE: assert property (@(posedge aclk) disable iff (!aresetn)
    (((st_r.dir | st_r.latch) & ~USED) == 16'h0000))
    else $error("Unimplemented bit held a one.");

  AST_READ_UPPER_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid |-> (rdata[31:16] == 16'h0000))
    else $error("Upper read bits nonzero.");

endmodule

// file: pio_pad_model.sv
// Model of the pad cells and the board levels behind the shared port.
module pio_pad_model
  import pio_pkg::*;
(
  // Pad drive from the port
  input wire pad_drive_s pad,
  // Level the board puts on a pin that nothing on chip drives
  input wire logic [15:0] board,
  // Level seen at the pads
  output logic [15:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released pin shows the board pattern, never the last driven value, so a stale read shows up.
  assign level = (pad.oe & pad.out) | (~pad.oe & board);
endmodule

// file: shared_parallel_io_port_tb_top.sv
// Self-checking testbench for the shared parallel I/O port.
module shared_parallel_io_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pio_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [1:0] bresp, rresp, rs_v;
  logic [15:0] board, level, lf, dir_m, lat_m, pen_m;
  logic [3:0] wstb;
  periph_drive_s periph;
  pad_drive_s pad;
  int num_errors, cmp_count;

  shared_parallel_io_port dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .periph(periph), .pad_in(level), .pad(pad));
  pio_pad_model pads (.pad(pad), .board(board), .level(level));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic tmo(int k);
    if (k >= 50) begin
      num_errors++;
      $display("Error handshake expected answer seen none");
      end_of_test();
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge aclk);
  endtask

  // ****************************************************************
  // Bus master
  // ****************************************************************
  task automatic wr(logic [11:0] a, logic [31:0] d);
    int k;
    k = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 50);
    tmo(k);
    rs_v = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a);
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 50);
    tmo(k);
    rd_v = rdata;
    rs_v = rresp;
    rready <= 1'b0;
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    tick(12);
    aresetn <= 1'b1;
    dir_m = PINS_USED;
    lat_m = 16'h0000;
    pen_m = 16'h0000;
    tick(1);
  endtask

  // Pad data, enable and pin read against the model, after the sync path has settled.
  task automatic check_pins();
    logic [15:0] own, oe_e, pin_e;
    tick(4);
    own = pen_m & periph.drive & PINS_USED;
    oe_e = own | (~dir_m & PINS_USED);
    pin_e = (own & periph.out) | (~own & oe_e & lat_m) | (~oe_e & board);
    chk("pad_oe", 32'(pad.oe), 32'(oe_e));
    chk("pad_out", 32'(pad.out & oe_e), 32'(pin_e & oe_e));
    rd(PINVAL_OFFSET);
    chk("pin_value", rd_v, 32'(pin_e & PINS_USED));
    chk("pin_resp", 32'(rs_v), 32'(RESP_OKAY));
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 56'h0;
    periph = '0;
    board = 16'hA5C3;
    wstb = 4'hF;
    lf = 16'hD722;
    num_errors = 0;
    cmp_count = 0;
    do_reset();
    rd(DIR_OFFSET);
    chk("dir_reset", rd_v, 32'(PINS_USED));
    rd(LATCH_OFFSET);
    chk("latch_reset", rd_v, 32'h0);
    check_pins();
    for (int i = 0; i < 16; i++) begin
      lf = lfsr(lf);
      wr(i[0] ? PINVAL_OFFSET : LATCH_OFFSET, {lf, lf});
      lat_m = lf & PINS_USED;
      chk("wr_resp", 32'(rs_v), 32'(RESP_OKAY));
      rd(LATCH_OFFSET);
      chk("latch", rd_v, 32'(lat_m));
      lf = lfsr(lf);
      wr(DIR_OFFSET, {16'h0000, lf});
      dir_m = lf & PINS_USED;
      rd(DIR_OFFSET);
      chk("dir", rd_v, 32'(dir_m));
      lf = lfsr(lf);
      wr(PERIPH_EN_OFFSET, {16'h0000, lf});
      pen_m = lf & PINS_USED;
      rd(PERIPH_EN_OFFSET);
      chk("periph_en", rd_v, 32'(pen_m));
      lf = lfsr(lf);
      periph.drive <= lf;
      lf = lfsr(lf);
      periph.out <= lf;
      lf = lfsr(lf);
      board <= lf;
      check_pins();
    end
    wstb <= 4'h1;
    wr(LATCH_OFFSET, 32'h0000_00FF);
    wstb <= 4'hF;
    lat_m = {lat_m[15:8], 8'hFF} & PINS_USED;
    rd(LATCH_OFFSET);
    chk("latch_strobe", rd_v, 32'(lat_m));
    wr(12'h010, 32'hFFFF_FFFF);
    chk("unmapped_wr", 32'(rs_v), 32'(RESP_SLVERR));
    rd(12'h010);
    chk("unmapped_rd", 32'(rs_v), 32'(RESP_SLVERR));
    chk("unmapped_data", rd_v, 32'h0);
    wr(DIR_OFFSET, 32'h0);
    do_reset();
    rd(DIR_OFFSET);
    chk("dir_rereset", rd_v, 32'(PINS_USED));
    check_pins();
    end_of_test();
  end
endmodule
